// File: verilog/clie_pkg.sv
package clie_pkg;

  // ==========================================================
  // Instruction decode
  // ==========================================================
  localparam logic [7:0] CLIE_SHIFT_MASK = 8'hf0;  // Shift class bits
  localparam logic [7:0] CLIE_SHIFT_CODE = 8'h10;
  localparam logic [7:0] CLIE_FUNC_MASK  = 8'he0;  // Function set class
  localparam logic [7:0] CLIE_FUNC_CODE  = 8'h20;
  localparam logic [7:0] CLIE_GLYPH_MASK = 8'hc0;  // Glyph address set
  localparam logic [7:0] CLIE_GLYPH_CODE = 8'h40;
  localparam logic [7:0] CLIE_ENTRY_MASK = 8'hfc;  // Entry mode set
  localparam logic [7:0] CLIE_ENTRY_CODE = 8'h04;
  localparam int         CLIE_BIT_CHAR   = 7;      // Char RAM address set
  localparam int         CLIE_BIT_SC     = 3;      // Shift target
  localparam int         CLIE_BIT_RL     = 2;      // Shift direction
  localparam int         CLIE_BIT_DL     = 4;      // Bus width select
  localparam int         CLIE_BIT_N      = 3;      // Line count
  localparam int         CLIE_BIT_F      = 2;      // Font height
  localparam int         CLIE_BIT_ID     = 1;      // Entry direction
  localparam int         CLIE_BIT_SH     = 0;      // Entry auto scroll

  // ==========================================================
  // Address map and resets
  // ==========================================================
  localparam logic [6:0] CLIE_ONE_LAST   = 7'h4f;  // One-line top
  localparam logic [6:0] CLIE_L1_LAST    = 7'h27;  // Line one top
  localparam logic [6:0] CLIE_L2_FIRST   = 7'h40;  // Line two base
  localparam logic [6:0] CLIE_L2_LAST    = 7'h67;  // Line two top
  localparam logic [5:0] CLIE_SHIFT_LAST = 6'h27;  // Shift wrap (40 cols)
  localparam int         CLIE_CHAR_WORDS = 128;
  localparam int         CLIE_GLYPH_WORDS = 64;
  localparam logic [3:0] CLIE_DUTY_ONE   = 4'h8;   // 1/8 duty
  localparam logic [3:0] CLIE_DUTY_TWO   = 4'hf;   // 1/16 duty (15+1)
  localparam logic [3:0] CLIE_ROWS_SMALL = 4'h7;   // 5x7 cell
  localparam logic [3:0] CLIE_ROWS_TALL  = 4'ha;   // 5x10 cell

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLIE_CLK_MHZ    = 50;
  localparam int CLIE_EXEC_US    = 38;             // Instruction time
  localparam int CLIE_EXEC_CYC   = CLIE_EXEC_US * CLIE_CLK_MHZ;
  localparam logic [10:0] CLIE_EXEC_LAST = 11'(CLIE_EXEC_CYC - 1);

endpackage : clie_pkg

// File: verilog/clie_engine.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RQ1: Byte 0001xxxx with select low is shift
// RQ2: Cursor shift steps counter down or up
// RQ3: Display shift moves image, cursor follows
// RQ4: Display shift applies to all lines together
// RQ5: Display shift leaves address counter unchanged
// RQ6: Byte 001xxxxx sets width, lines, font
// RQ7: Width one eight lines, zero two nibbles
// RQ8: Line select gives 1/8 or 1/16 duty
// RQ9: Font select gives 5x7 or 5x10 cell
// RQ10: Host configures first, except status reads
// RQ11: 01xxxxxx loads counter, selects glyph RAM
// RQ12: 1xxxxxxx loads counter, selects char RAM
// RQ13: One-line char addresses span 00 to 4f
// RQ14: Two-line addresses 00-27 and 40-67
// RQ15: Status read gives busy and counter
// RQ16: Busy device refuses new instructions
// RQ17: One counter shared, set by last instruction
// RQ18: Data write stores, steps, maybe scrolls
// RQ19: Data read returns, steps, never scrolls
// RQ20: Read valid after address set or prior read
// RQ21: Cursor shift prepares char RAM read path
// RQ22: Entry direction picks increment or decrement
// RQ23: Auto scroll on char write, left if incrementing
// RQ24: Non-polling host waits 38 us
// RQ25: Counter steps only when busy clears; a cursor shift steps it when accepted
// RQ26: Don't-care instruction bits are ignored
// RQ27: Four-bit mode sends upper nibble first
module clie_engine
  import clie_pkg::*;
(
  input  wire logic       clk_in,            // 50 MHz
  input  wire logic       resetn_in,         // Async, active low
  // Host bus write request side (valid/ready)
  input  wire logic       req_valid_in,      // Transfer strobe
  output logic            req_ready_out,     // Not busy, takes transfer
  input  wire logic       cmd_data_select_in,// 0 command, 1 data
  input  wire logic       read_nwrite_in,    // 1 read, 0 write
  input  wire logic [7:0] data_in,           // Upper nibble used in 4-bit
  // Read answer side (two-entry buffer)
  output logic            rd_valid_out,      // Read word/nibble waiting
  input  wire logic       rd_ready_in,       // Host takes it
  output logic [7:0]      rd_data_out,       // Answer, nibble on [7:4]
  // Configuration and display state
  output logic            busy_indicator_out,
  output logic [6:0]      ram_addr_counter_out,
  output logic            bus_width_sel_out, // 1 eight lines
  output logic            two_line_out,
  output logic [3:0]      duty_out,          // Mux duty divisor
  output logic [3:0]      font_rows_out,     // Cell height in dots
  output logic [5:0]      display_shift_out, // Image offset, all lines
  output logic            glyph_sel_out      // 1 glyph RAM targeted
);

  // ==========================================================
  // State
  // ==========================================================
  logic [7:0]  char_code_ram [CLIE_CHAR_WORDS];   // Display codes
  logic [7:0]  glyph_ram     [CLIE_GLYPH_WORDS];  // Glyph rows
  logic [6:0]  ram_addr_counter_reg;               // Shared counter
  logic [10:0] busy_cnt_reg;                       // Execution timer
  logic        busy_reg;
  logic        step_pend_reg;                      // Deferred step
  logic        pend_wr_reg;                        // Deferred step is a write
  logic        width_reg;                          // Bus width select
  logic        lines_reg;
  logic        font_reg;
  logic        glyph_reg;                          // RAM target
  logic        incr_reg;                           // Entry direction
  logic        scroll_reg;                         // auto_scroll_en
  logic [5:0]  shift_reg;                          // Image offset
  logic [7:0]  prefetch_reg;                       // Read path latch
  logic        low_half_reg;                       // Second nibble due
  logic [3:0]  hold_nib_reg;                       // First write nibble
  logic [7:0]  rd_word_reg;                        // Word being split

  // Two-entry answer buffer
  logic [7:0]  buf_mem [2];
  logic        buf_wp_reg;
  logic        buf_rp_reg;
  logic [1:0]  buf_cnt_reg;

  // ==========================================================
  // Transfer assembly
  // ==========================================================
  logic        buf_full;
  logic        take;         // Transfer accepted
  logic        byte_done;    // Whole byte now complete
  logic [7:0]  wr_byte;      // Assembled write byte
  logic        rd_cycle;
  logic        status_rd;
  logic        exec;         // Busy-gated instruction or data op
  logic [7:0]  rd_byte;      // Byte answering a read
  logic [7:0]  push_word;
  logic        push;
  logic        pop;
  logic [6:0]  step_addr;    // Counter after one entry step
  logic [6:0]  cur_addr;     // Counter after cursor move
  logic [6:0]  clamped;      // Address legal for line mode
  logic [6:0]  fetch_addr;   // Counter value the read latch follows
  logic        busy_next;    // Busy state after this edge
  logic [1:0]  cnt_next;     // Buffer fill after this edge

  assign buf_full  = buf_cnt_reg == 2'h2;
  assign rd_cycle  = read_nwrite_in;
  assign status_rd = rd_cycle && !cmd_data_select_in;
  // Status reads bypass busy; everything else waits for it
  assign take      = req_valid_in
                     && (status_rd ? !buf_full : req_ready_out);  // RQ16
  assign byte_done = width_reg || low_half_reg;                 // RQ7
  assign wr_byte   = width_reg ? data_in
                     : {hold_nib_reg, data_in[7:4]};           // RQ27
  assign exec      = take && !status_rd && byte_done && !rd_cycle
                     || take && rd_cycle && !status_rd && !low_half_reg;
  assign rd_byte   = status_rd ? {busy_reg, ram_addr_counter_reg}
                     : prefetch_reg;                            // RQ15
  assign push_word = (width_reg || !low_half_reg) ? rd_byte
                     : {rd_word_reg[3:0], 4'h0};
  assign push      = take && rd_cycle;
  assign pop       = rd_valid_out && rd_ready_in;
  assign step_addr = incr_reg ? 7'(ram_addr_counter_reg + 7'h1)
                              : 7'(ram_addr_counter_reg - 7'h1);  // RQ22
  // Ready shows exactly what the next edge accepts, except status reads
  assign fetch_addr = step_pend_reg ? cur_addr : ram_addr_counter_reg;
  assign busy_next  = exec || (busy_reg && busy_cnt_reg != 11'h000);
  assign cnt_next   = 2'(buf_cnt_reg + {1'b0, push} - {1'b0, pop});

  // Keep char address inside the active line map
  always_comb begin
    clamped = step_addr;
    if (!lines_reg && step_addr > CLIE_ONE_LAST) begin           // RQ13
      clamped = incr_reg ? 7'h00 : CLIE_ONE_LAST;
    end else if (lines_reg && step_addr > CLIE_L1_LAST
                 && step_addr < CLIE_L2_FIRST) begin             // RQ14
      clamped = incr_reg ? CLIE_L2_FIRST : CLIE_L1_LAST;
    end else if (lines_reg && step_addr > CLIE_L2_LAST) begin
      clamped = incr_reg ? 7'h00 : CLIE_L2_LAST;
    end
    cur_addr = glyph_reg ? {1'b0, step_addr[5:0]} : clamped;
  end

  // ==========================================================
  // Nibble tracking (4-bit bus)
  // ==========================================================
  // Each half is one transfer; only a data read waits out busy between its halves
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      low_half_reg <= 1'b0;
      hold_nib_reg <= 4'h0;
      rd_word_reg  <= 8'h00;
    end else if (take && !width_reg) begin                       // RQ7
      low_half_reg <= !low_half_reg;
      if (!low_half_reg) begin
        hold_nib_reg <= data_in[7:4];                            // RQ27
        rd_word_reg  <= rd_byte;
      end
    end
  end

  // ==========================================================
  // Busy timer and deferred counter step
  // ==========================================================
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      busy_reg     <= 1'b0;
      busy_cnt_reg <= 11'h000;
    end else if (exec) begin
      busy_reg     <= 1'b1;
      busy_cnt_reg <= CLIE_EXEC_LAST;
    end else if (busy_reg) begin
      if (busy_cnt_reg == 11'h000) begin
        busy_reg <= 1'b0;
      end else begin
        busy_cnt_reg <= 11'(busy_cnt_reg - 11'h001);
      end
    end
  end

  // ==========================================================
  // Instruction execution
  // ==========================================================
  // Counter is only ever changed here, last op wins
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ram_addr_counter_reg <= 7'h00;
      step_pend_reg        <= 1'b0;
      pend_wr_reg          <= 1'b0;
      width_reg            <= 1'b1;
      lines_reg            <= 1'b0;
      font_reg             <= 1'b0;
      glyph_reg            <= 1'b0;
      incr_reg             <= 1'b1;
      scroll_reg           <= 1'b0;
      shift_reg            <= 6'h00;
    end else begin
      // Data op step lands as busy drops
      if (step_pend_reg && busy_reg && busy_cnt_reg == 11'h000) begin
        ram_addr_counter_reg <= cur_addr;                        // RQ25
        step_pend_reg        <= 1'b0;
      end
      if (exec && !cmd_data_select_in) begin
        // Don't-care bits never reach a decision
        if (wr_byte[CLIE_BIT_CHAR]) begin                        // RQ26
          ram_addr_counter_reg <= wr_byte[6:0];                  // RQ12
          glyph_reg            <= 1'b0;
        end else if ((wr_byte & CLIE_GLYPH_MASK) == CLIE_GLYPH_CODE) begin
          ram_addr_counter_reg <= {1'b0, wr_byte[5:0]};          // RQ11
          glyph_reg            <= 1'b1;
        end else if ((wr_byte & CLIE_FUNC_MASK) == CLIE_FUNC_CODE) begin
          width_reg <= wr_byte[CLIE_BIT_DL];                     // RQ6
          lines_reg <= wr_byte[CLIE_BIT_N];
          font_reg  <= wr_byte[CLIE_BIT_F];
        end else if ((wr_byte & CLIE_SHIFT_MASK) == CLIE_SHIFT_CODE) begin
          if (!wr_byte[CLIE_BIT_SC]) begin                       // RQ1
            ram_addr_counter_reg <= wr_byte[CLIE_BIT_RL]
              ? 7'(ram_addr_counter_reg + 7'h1)
              : 7'(ram_addr_counter_reg - 7'h1);                 // RQ2
          end else begin
            // One offset for all lines; counter untouched
            shift_reg <= wr_byte[CLIE_BIT_RL]                    // RQ3 RQ4 RQ5
              ? ((shift_reg == CLIE_SHIFT_LAST) ? 6'h00
                 : 6'(shift_reg + 6'h01))
              : ((shift_reg == 6'h00) ? CLIE_SHIFT_LAST
                 : 6'(shift_reg - 6'h01));
          end
        end else if ((wr_byte & CLIE_ENTRY_MASK) == CLIE_ENTRY_CODE) begin
          incr_reg   <= wr_byte[CLIE_BIT_ID];
          scroll_reg <= wr_byte[CLIE_BIT_SH];
        end
      end else if (exec) begin
        step_pend_reg <= 1'b1;                                   // RQ18 RQ19
        pend_wr_reg   <= !rd_cycle;
        // Scroll only on char RAM writes
        if (!rd_cycle && scroll_reg && !glyph_reg) begin         // RQ23
          shift_reg <= incr_reg
            ? ((shift_reg == 6'h00) ? CLIE_SHIFT_LAST
               : 6'(shift_reg - 6'h01))
            : ((shift_reg == CLIE_SHIFT_LAST) ? 6'h00
               : 6'(shift_reg + 6'h01));
        end
      end
    end
  end

  // ==========================================================
  // RAM write port
  // ==========================================================
  always_ff @(posedge clk_in) begin
    if (exec && cmd_data_select_in && !rd_cycle) begin
      if (glyph_reg) begin
        glyph_ram[ram_addr_counter_reg[5:0]] <= wr_byte;         // RQ18
      end else begin
        char_code_ram[ram_addr_counter_reg] <= wr_byte;
      end
    end
  end

  // ==========================================================
  // Read path latch
  // ==========================================================
  // Latch refreshes after any instruction or a read, never after
  // a write, so a read right after a write returns stale data
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prefetch_reg <= 8'h00;
    end else if (busy_reg && busy_cnt_reg == 11'h000
                 && !(step_pend_reg && pend_wr_reg)) begin       // RQ20 RQ21
      prefetch_reg <= glyph_reg ? glyph_ram[fetch_addr[5:0]]
                      : char_code_ram[fetch_addr];
    end
  end

  // ==========================================================
  // Two-entry answer buffer
  // ==========================================================
  // Holding two entries lets a stalled host lose no word
  always_ff @(posedge clk_in) begin
    if (push) begin
      buf_mem[buf_wp_reg] <= push_word;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      buf_wp_reg  <= 1'b0;
      buf_rp_reg  <= 1'b0;
      buf_cnt_reg <= 2'h0;
    end else begin
      if (push) begin
        buf_wp_reg <= !buf_wp_reg;
      end
      if (pop) begin
        buf_rp_reg <= !buf_rp_reg;
      end
      buf_cnt_reg <= cnt_next;
    end
  end

  // ==========================================================
  // Registered outputs
  // ==========================================================
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_valid_out <= 1'b0;
      rd_data_out  <= 8'h00;
    end else begin
      // Present head entry; no bypass, a word pushed into an empty buffer shows after it is stored
      if (pop || !rd_valid_out) begin
        if (buf_cnt_reg - {1'b0, pop} != 2'h0) begin
          rd_valid_out <= 1'b1;
          rd_data_out  <= buf_mem[buf_rp_reg ^ pop];
        end else begin
          rd_valid_out <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      req_ready_out        <= 1'b0;
      busy_indicator_out   <= 1'b0;
      ram_addr_counter_out <= 7'h00;
      bus_width_sel_out    <= 1'b1;
      two_line_out         <= 1'b0;
      duty_out             <= CLIE_DUTY_ONE;
      font_rows_out        <= CLIE_ROWS_SMALL;
      display_shift_out    <= 6'h00;
      glyph_sel_out        <= 1'b0;
    end else begin
      req_ready_out        <= !busy_next && cnt_next != 2'h2;     // RQ16
      busy_indicator_out   <= busy_next;
      ram_addr_counter_out <= ram_addr_counter_reg;               // RQ17
      bus_width_sel_out    <= width_reg;
      two_line_out         <= lines_reg;
      duty_out             <= lines_reg ? CLIE_DUTY_TWO : CLIE_DUTY_ONE; // RQ8
      font_rows_out        <= font_reg ? CLIE_ROWS_TALL : CLIE_ROWS_SMALL; // RQ9
      display_shift_out    <= shift_reg;
      glyph_sel_out        <= glyph_reg;
    end
  end

endmodule : clie_engine

`default_nettype wire

// File: test/clie_host.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Host model: drives the bus at falling edges
module clie_host (
  input  wire logic       clk_in,      // Bench clock
  input  wire logic       ready_in,    // Device takes transfers
  input  wire logic       busy_in,     // Device busy flag
  output var  logic       valid_out,   // Transfer offered
  output var  logic       sel_out,     // 0 command, 1 data
  output var  logic       rnw_out,     // 1 read
  output var  logic [7:0] data_out,    // Bus lines
  output var  logic       rd_ready_out // Takes answers
);
  logic wide  = 1'b1; // Eight-line transfers
  logic stall = 1'b0; // Answer side held off
  // Idle bus, answer side follows stall
  initial begin
    valid_out = 1'b0;
    sel_out = 1'b0;
    rnw_out = 1'b0;
    data_out = 8'h00;
    rd_ready_out = 1'b1;
    forever begin
      @(negedge clk_in);
      rd_ready_out <= !stall;
    end
  end
  // One beat, held until taken; a status read shows no
  // acceptance on ready, so it stands for one edge only
  task automatic beat(input logic rs, input logic rd,
                      input logic [7:0] d);
    @(negedge clk_in);
    valid_out = 1'b1;
    sel_out = rs;
    rnw_out = rd;
    data_out = d;
    do begin
      @(posedge clk_in);
    end while (!(ready_in || (rd && !rs)));
    @(negedge clk_in);
    valid_out = 1'b0;
    data_out = ~d; // Released lines lose the last value
  endtask : beat
  // Whole byte, split upper nibble first on a narrow bus
  task automatic send(input logic rs, input logic rd,
                      input logic [7:0] b);
    if (wide) beat(rs, rd, b);
    else begin
      beat(rs, rd, {b[7:4], ~b[3:0]});
      beat(rs, rd, {b[3:0], b[7:4]});
    end
  endtask : send
  // Wait out the busy flag; a hang ends at the bench timeout
  task automatic settle();
    repeat (3) @(negedge clk_in);
    while (busy_in) begin
      @(negedge clk_in);
    end
    repeat (2) @(negedge clk_in);
  endtask : settle
endmodule : clie_host
`default_nettype wire

// File: test/clie_engine_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Port checker for the instruction engine
module clie_chk
  import clie_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       resetn_in,
  input wire logic       req_valid_in,
  input wire logic       req_ready_out,
  input wire logic       cmd_data_select_in,
  input wire logic       read_nwrite_in,
  input wire logic       rd_valid_out,
  input wire logic       rd_ready_in,
  input wire logic [7:0] rd_data_out,
  input wire logic       busy_indicator_out,
  input wire logic [6:0] ram_addr_counter_out,
  input wire logic       bus_width_sel_out,
  input wire logic       two_line_out,
  input wire logic [3:0] duty_out,
  input wire logic [3:0] font_rows_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic [11:0] busy_cnt_reg; // High cycles of this busy period
  // Length of each busy period
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) busy_cnt_reg <= 12'h000;
    else if (busy_indicator_out) busy_cnt_reg <= busy_cnt_reg + 12'h001;
    else busy_cnt_reg <= 12'h000;
  end
  // Byte-completing transfer on an idle wide bus
  sequence s_wr_take;
    req_valid_in && req_ready_out && !busy_indicator_out &&
      bus_width_sel_out && !(read_nwrite_in && !cmd_data_select_in);
  endsequence
  sequence s_busy3;
    busy_indicator_out [*3];
  endsequence
  // Status read while no answer is presented
  sequence s_st_take;
    req_valid_in && read_nwrite_in && !cmd_data_select_in && !rd_valid_out;
  endsequence
  chk_busy_rise: assert property (s_wr_take |-> ##[1:2] busy_indicator_out)
    else $error("busy missing after an accepted byte");
  chk_busy_len: assert property ($fell(busy_indicator_out) |-> busy_cnt_reg == 12'(CLIE_EXEC_CYC))
    else $error("busy period has the wrong length");
  chk_ac_hold: assert property (s_busy3 |-> $stable(ram_addr_counter_out))
    else $error("address counter moved while busy");
  chk_ready_low: assert property (s_busy3 |-> !req_ready_out)
    else $error("ready shown while busy");
  chk_reset_out: assert property ($past(resetn_in) == 1'b0 |-> bus_width_sel_out && duty_out == CLIE_DUTY_ONE && font_rows_out == CLIE_ROWS_SMALL && ram_addr_counter_out == 7'h00)
    else $error("wrong state after reset");
  chk_duty_lines: assert property (duty_out == (two_line_out ? CLIE_DUTY_TWO : CLIE_DUTY_ONE))
    else $error("duty does not match line count");
  chk_cfg_quiet: assert property ($changed(two_line_out) || $changed(font_rows_out) |-> ($past(busy_indicator_out) || busy_indicator_out) or (##1 busy_indicator_out))
    else $error("configuration changed without an instruction");
  chk_rd_hold: assert property (rd_valid_out && !rd_ready_in |=> rd_valid_out && $stable(rd_data_out))
    else $error("answer dropped while stalled");
  chk_rd_answer: assert property (s_st_take |-> ##[1:3] rd_valid_out)
    else $error("status answer late");
endmodule : clie_chk
bind clie_engine clie_chk i_chk (
  .clk_in, .resetn_in, .req_valid_in, .req_ready_out,
  .cmd_data_select_in, .read_nwrite_in, .rd_valid_out, .rd_ready_in,
  .rd_data_out, .busy_indicator_out, .ram_addr_counter_out,
  .bus_width_sel_out, .two_line_out, .duty_out, .font_rows_out
);
`default_nettype wire

// File: test/char_lcd_instruction_engine_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Bench: host model drives, a watcher checks answers
module char_lcd_instruction_engine_tb
  import clie_pkg::*;
;
  logic        clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        valid, sel, rnw, rd_ready, ready, rd_valid, busy;
  logic        width_o, two_o, glyph_o;
  logic [7:0]  data, rd_data, w1, w2;
  logic [6:0]  ac_o, ac, a; // Design counter, model, base address
  logic [3:0]  duty_o, font_o;
  logic [5:0]  shift_o, sh0, g;
  logic [15:0] q[$]; // Mask and value of each pending answer
  int          n_mismatch = 0;
  int          check_count = 0;
  int          cyc = 0;
  initial forever #10 clk_in = ~clk_in;
  clie_engine i_clie_engine (.clk_in(clk_in), .resetn_in(resetn_in),
    .req_valid_in(valid), .req_ready_out(ready),
    .cmd_data_select_in(sel), .read_nwrite_in(rnw), .data_in(data),
    .rd_valid_out(rd_valid), .rd_ready_in(rd_ready),
    .rd_data_out(rd_data), .busy_indicator_out(busy),
    .ram_addr_counter_out(ac_o), .bus_width_sel_out(width_o),
    .two_line_out(two_o), .duty_out(duty_o), .font_rows_out(font_o),
    .display_shift_out(shift_o), .glyph_sel_out(glyph_o));
  clie_host u_host (.clk_in(clk_in), .ready_in(ready), .busy_in(busy),
    .valid_out(valid), .sel_out(sel), .rnw_out(rnw), .data_out(data),
    .rd_ready_out(rd_ready));
  task automatic stop_test();
    $display("Mismatches %0d, checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  // Port value compare
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Answer compare under the note's mask
  task automatic chk_rd(input logic [15:0] e, input logic [7:0] s);
    check_count++;
    if ((s & e[15:8]) !== e[7:0]) begin
      n_mismatch++;
      $display("Error rd_data expected %h seen %h", e[7:0], s);
    end
  endtask : chk_rd
  // Narrow bus answers upper nibble, then lower
  function automatic void expect_rd(input logic [7:0] v);
    if (u_host.wide) q.push_back({8'hff, v});
    else begin
      q.push_back({8'hf0, v[7:4], 4'h0});
      q.push_back({8'hf0, v[3:0], 4'h0});
    end
  endfunction : expect_rd
  // Bounded wait until every noted answer was seen
  task automatic drain();
    int n;
    n = 0;
    while (q.size() > 0 && n < 200) begin
      @(negedge clk_in);
      n++;
    end
    if (q.size() > 0) begin
      n_mismatch++;
      $display("Error rd_data expected answer seen none");
      q.delete();
    end
  endtask : drain
  task automatic cmd(input logic [7:0] b);
    u_host.send(1'b0, 1'b0, b);
    u_host.settle();
  endtask : cmd
  task automatic stat(input logic eb);
    expect_rd({eb, ac});
    u_host.send(1'b0, 1'b1, 8'h00);
    drain();
  endtask : stat
  task automatic rdata(input logic [7:0] v);
    expect_rd(v);
    u_host.send(1'b1, 1'b1, 8'h00);
    drain();
    u_host.settle();
  endtask : rdata
  // Watcher and hang limit
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc > 60000) begin
      n_mismatch++;
      stop_test();
    end
    if (rd_valid && rd_ready) begin
      if (q.size() == 0) begin
        n_mismatch++;
        $display("Error rd_data expected none seen %h", rd_data);
      end
      else chk_rd(q.pop_front(), rd_data);
    end
  end
  initial begin
    w1 = 8'($urandom(5));
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    resetn_in = 1'b1;
    @(negedge clk_in);
    chk("width", 8'h01, 8'(width_o));
    chk("duty", 8'(CLIE_DUTY_ONE), 8'(duty_o));
    chk("font", 8'(CLIE_ROWS_SMALL), 8'(font_o));
    chk("ac", 8'h00, 8'(ac_o));
    for (int k = 0; k < 4; k++) begin
      cmd(8'h30 | 8'(k << 2) | 8'($urandom % 4));
      chk("lines", 8'(k[1]), 8'(two_o));
      chk("duty", k[1] ? 8'(CLIE_DUTY_TWO) : 8'(CLIE_DUTY_ONE), 8'(duty_o));
      chk("font", k[0] ? 8'(CLIE_ROWS_TALL) : 8'(CLIE_ROWS_SMALL), 8'(font_o));
    end
    a = 7'h41 + 7'($urandom % 38); // Line two, clear of both ends
    cmd({1'b1, a});
    ac = a;
    chk("glyph", 8'h00, 8'(glyph_o));
    stat(1'b0);
    for (int k = 0; k < 4; k++) begin
      cmd(8'h10 | 8'(k << 2) | 8'($urandom % 4));
      if (k < 2) ac = k[0] ? ac + 7'h01 : ac - 7'h01;
      if (k == 2) chk("moved", 8'h01, 8'(shift_o != 6'h00));
      chk("ac", 8'(ac), 8'(ac_o));
    end
    chk("image", 8'h00, 8'(shift_o));
    cmd(8'h07);
    w1 = 8'($urandom);
    w2 = 8'($urandom);
    u_host.send(1'b1, 1'b0, w1);
    stat(1'b1);
    u_host.settle();
    ac = ac + 7'h01;
    chk("scroll", 8'h01, 8'(shift_o != 6'h00));
    stat(1'b0);
    u_host.send(1'b1, 1'b0, w2);
    u_host.settle();
    cmd({1'b1, a});
    ac = a;
    sh0 = shift_o;
    rdata(w1);
    rdata(w2);
    chk("image", 8'(sh0), 8'(shift_o));
    cmd(8'h10);
    rdata(w2);
    cmd(8'h05);
    g = 6'h01 + 6'($urandom % 63);
    cmd({2'b01, g});
    ac = {1'b0, g} - 7'h01;
    chk("glyph", 8'h01, 8'(glyph_o));
    sh0 = shift_o;
    u_host.send(1'b1, 1'b0, w1);
    u_host.settle();
    stat(1'b0);
    chk("image", 8'(sh0), 8'(shift_o));
    // Fill the answer buffer with the reader stalled
    u_host.stall = 1'b1;
    repeat (2) @(negedge clk_in);
    expect_rd({1'b0, ac});
    expect_rd({1'b0, ac});
    repeat (3) u_host.send(1'b0, 1'b1, 8'h00);
    chk("ready", 8'h00, 8'(ready));
    u_host.stall = 1'b0;
    drain();
    repeat (8) @(negedge clk_in);
    cmd(8'h28);
    u_host.wide = 1'b0;
    chk("width", 8'h00, 8'(width_o));
    cmd({1'b1, a});
    ac = a;
    stat(1'b0);
    rdata(w1);
    stop_test();
  end
endmodule : char_lcd_instruction_engine_tb
`default_nettype wire
